// ---- core/start_stop_consts.svh ----
`ifndef START_STOP_CONSTS_SVH
`define START_STOP_CONSTS_SVH

// Clock and sequencing time base
`define CLK_PERIOD_NS 10
`define TICK_TIME_MS 10
`define TICK_CYCLES ((`TICK_TIME_MS * 1000000) / `CLK_PERIOD_NS)
// A 0.1 s setting is ten 10 ms ticks
`define TENTH_IN_TICKS 20'h0000a

// Start method codes
`define START_DIRECT 2'h0
`define START_DC_BRAKE 2'h1
`define START_TRACK_ONE 2'h2
`define START_TRACK_TWO 2'h3

// Ramp profile codes
`define RAMP_LINEAR 1'h0
`define RAMP_S_CURVE 1'h1
// S-curve eases within this band of the target (0.01 Hz units)
`define S_CURVE_BAND 16'h0064

// Reversal policy codes
`define REV_AT_ZERO 2'h0
`define REV_AT_START_FREQ 2'h1
`define REV_AT_HALT_SPEED 2'h2

// Halt speed source codes
`define HALT_SRC_SETPOINT 1'h0
`define HALT_SRC_MEASURED 1'h1

// Under limit action codes
`define UNDER_RUN_AT_LIMIT 2'h0
`define UNDER_STOP 2'h1
`define UNDER_SLEEP 2'h2

// Power-up guard: honour a terminal run present at power-up
`define GUARD_HONOUR 1'h1

// Documented defaults, for software that loads the settings
`define DEF_DIRECT_START_FREQ 16'h0032
`define DEF_START_FREQ_HOLD_TIME 9'h000
`define DEF_HALT_SPEED_THRESHOLD 16'h0032
`define DEF_HALT_SPEED_SOURCE 1'h1
`define DEF_OUTAGE_RESTART_WAIT 16'h000a

// Power-up settle: synchroniser depth plus one
`define INIT_SETTLE 2'h3

`endif

// ---- core/start_stop_pkg.sv ----
package start_stop_pkg;

  // Settings, in hardware units: freq 0.01 Hz, current 0.1 %,
  // *_time with 9/13/16 bits in 0.01 s or 0.1 s as noted
  typedef struct packed {
    logic [1:0] start_method_select;
    logic [15:0] direct_start_freq;
    logic [8:0] start_freq_hold_time;      // 0.1 s
    logic [9:0] prestart_brake_current;
    logic [12:0] prestart_brake_time;      // 0.01 s
    logic ramp_profile_select;
    logic [15:0] stop_brake_threshold_freq;
    logic [12:0] stop_brake_wait_time;     // 0.01 s
    logic [9:0] stop_brake_current;
    logic [12:0] stop_brake_time;          // 0.01 s
    logic [15:0] reversal_dead_time;       // 0.1 s
    logic [1:0] reversal_policy_select;
    logic [15:0] halt_speed_threshold;
    logic halt_speed_source_select;
    logic poweron_run_guard;
    logic [1:0] under_limit_action;
    logic [15:0] sleep_wake_delay;         // 0.1 s
    logic outage_restart_enable;
    logic [15:0] outage_restart_wait;      // 0.1 s
    logic [15:0] accel_step;               // per 10 ms tick
    logic [15:0] decel_step;               // per 10 ms tick
    logic [15:0] lower_limit_freq;
    logic svpwm_mode;
    logic terminal_channel;
  } cfg_t;

  typedef enum logic [3:0] {
    S_IDLE, S_PRE_BRAKE, S_TRACK, S_HOLD, S_RUN, S_DECEL, S_REV_DECEL,
    S_DEAD, S_STOP_WAIT, S_STOP_BRAKE, S_SLEEP, S_OUTAGE, S_RESTART
  } seq_state_t;

  typedef struct packed {
    logic [15:0] freq;
    logic dir;
    logic pwm_enable;
    logic brake_active;
    logic [9:0] brake_level;
    logic track_req;
    logic track_variant;
    logic s_curve_active;
    logic sleeping;
    logic running;
    logic halt_reached;
  } drive_out_t;

  typedef struct packed {
    seq_state_t st;
    logic [19:0] tick_cnt;
    logic tick;
    logic [19:0] timer;
    logic run_s1;
    logic run_s2;
    logic dir_s1;
    logic dir_s2;
    logic sup_s1;
    logic sup_s2;
    logic [1:0] init_cnt;
    logic start_block;
    logic was_running;
    logic sleep_pend;
    drive_out_t o;
  } seq_regs_t;

endpackage

// ---- core/drive_start_stop_sequencer.sv ----
// How it works
// - Power-up, outage restart, fault-reset starts differ.
// - Method codes: direct, DC brake, track one/two.
// - Direct start begins at starting frequency.
// - Hold starting frequency for hold time first.
// - Pre-start DC brake at its own current.
// - Pre-start brake lasts its time, then start.
// - Ramp straight for 0, S-curve for 1.
// - Stop braking begins at threshold frequency.
// - Wait programmed time before stop braking.
// - Stop braking at programmed current level.
// - Stop braking lasts programmed duration.
// - Dead-zone interval when direction changes.
// - Reverse at zero, start freq, or halt speed.
// - Halt speed compares setpoint or measured speed.
// - Terminal run at power-up ignored unless enabled.
// - Under limit: run at limit, stop, sleep.
// - Sleep waits wake delay before resuming.
// - Optional restart after outage wait time.
`timescale 1ns/100ps
`default_nettype none
`include "start_stop_consts.svh"

module drive_start_stop_sequencer
  import start_stop_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Pins from the command terminals and supply monitor
  input wire logic run_cmd,
  input wire logic dir_cmd,
  input wire logic supply_ok,
  // Same-domain status from the drive
  input wire logic fault_active,
  input wire logic fault_auto_reset,
  input wire logic track_done,
  input wire logic [15:0] track_freq,
  input wire logic [15:0] target_freq,
  input wire logic [15:0] meas_freq,
  // Settings
  input wire cfg_t cfg,
  // Drive commands
  output drive_out_t drv
);

  seq_regs_t r_q;
  seq_regs_t r_d;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Non-zero times get one spare tick: the prescaler may cut the first one short
  function automatic logic [19:0] ticks_of(input logic [15:0] val, input logic tenth);
    logic [19:0] t;
    t = {4'h0, val};
    if (tenth) begin
      t = 20'(t * `TENTH_IN_TICKS);
    end
    return (val != 16'h0000) ? 20'(t + 20'h00001) : t;
  endfunction

  // One ramp step toward the goal; S-curve halves the step near it
  function automatic logic [15:0] ramp_to(input logic [15:0] cur, input logic [15:0] goal,
                                          input logic [15:0] up, input logic [15:0] dn,
                                          input logic scurve);
    logic [15:0] diff;
    logic [15:0] step;
    diff = (cur > goal) ? 16'(cur - goal) : 16'(goal - cur);
    step = (cur > goal) ? dn : up;
    if (scurve && diff < `S_CURVE_BAND) begin
      step = {1'b0, step[15:1]} | 16'h0001;
    end
    if (step >= diff) begin
      return goal;
    end
    return (cur > goal) ? 16'(cur - step) : 16'(cur + step);
  endfunction

  // Enter the start sequence chosen by the method code
  function automatic seq_regs_t begin_start(input seq_regs_t s, input cfg_t c);
    seq_regs_t n;
    n = s;
    n.o.pwm_enable = 1'b1;
    n.o.running = 1'b1;
    n.o.sleeping = 1'b0;
    n.sleep_pend = 1'b0;
    unique case (c.start_method_select)
      `START_DC_BRAKE: begin
        n.st = S_PRE_BRAKE;
        n.o.freq = 16'h0000;
        n.o.brake_active = 1'b1;
        n.o.brake_level = c.prestart_brake_current;
        n.timer = ticks_of({3'h0, c.prestart_brake_time}, 1'b0);
      end
      `START_TRACK_ONE, `START_TRACK_TWO: begin
        n.st = S_TRACK;
        n.o.track_req = 1'b1;
        n.o.track_variant = c.start_method_select[0];
      end
      default: begin
        n.st = S_HOLD;
        n.o.freq = c.direct_start_freq;
        n.timer = ticks_of({7'h00, c.start_freq_hold_time}, 1'b1);
      end
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  logic [15:0] goal;
  logic [15:0] halt_speed;
  logic under_limit;
  logic rev_point;
  logic timer_done;
  logic run_ok;

  always_comb begin
    r_d = r_q;
    r_d.tick = 1'b0;

    // Synchronisers
    r_d.run_s1 = run_cmd;
    r_d.run_s2 = r_q.run_s1;
    r_d.dir_s1 = dir_cmd;
    r_d.dir_s2 = r_q.dir_s1;
    r_d.sup_s1 = supply_ok;
    r_d.sup_s2 = r_q.sup_s1;

    // 10 ms time base
    if (r_q.tick_cnt >= 20'(TICK_CYCLES - 1)) begin
      r_d.tick_cnt = 20'h00000;
      r_d.tick = 1'b1;
    end else begin
      r_d.tick_cnt = 20'(r_q.tick_cnt + 20'h00001);
    end
    timer_done = (r_q.timer == 20'h00000);
    if (r_q.tick && !timer_done) begin
      r_d.timer = 20'(r_q.timer - 20'h00001);
    end

    // Halt speed: SVPWM only has the setpoint to go by
    if (cfg.halt_speed_source_select == `HALT_SRC_MEASURED && !cfg.svpwm_mode) begin
      halt_speed = meas_freq;
    end else begin
      halt_speed = r_q.o.freq;
    end
    r_d.o.halt_reached = (halt_speed <= cfg.halt_speed_threshold);

    unique case (cfg.reversal_policy_select)
      `REV_AT_ZERO: rev_point = (r_q.o.freq == 16'h0000);
      `REV_AT_START_FREQ: rev_point = (r_q.o.freq <= cfg.direct_start_freq);
      `REV_AT_HALT_SPEED: rev_point = r_q.o.halt_reached;
      default: rev_point = (r_q.o.freq == 16'h0000);
    endcase

    under_limit = (target_freq < cfg.lower_limit_freq);
    goal = target_freq;
    if (under_limit && cfg.under_limit_action == `UNDER_RUN_AT_LIMIT) begin
      goal = cfg.lower_limit_freq;
    end

    r_d.o.s_curve_active = (cfg.ramp_profile_select == `RAMP_S_CURVE);

    // Power-up settling: synchronisers must hold real pin levels first
    if (r_q.init_cnt != `INIT_SETTLE) begin
      r_d.init_cnt = 2'(r_q.init_cnt + 2'h1);
      if (r_d.init_cnt == `INIT_SETTLE) begin
        r_d.start_block = r_q.run_s2 && cfg.terminal_channel &&
                          cfg.poweron_run_guard != `GUARD_HONOUR;
      end
    end
    // A released run command lifts any block, except while a fault is active
    if (!r_q.run_s2) begin
      r_d.start_block = 1'b0;
    end
    // Faults need a fresh run unless reset automatically
    if (fault_active) begin
      r_d.start_block = 1'b1;
    end else if (fault_auto_reset) begin
      r_d.start_block = 1'b0;
    end
    run_ok = r_q.run_s2 && !r_q.start_block && (r_q.init_cnt == `INIT_SETTLE) &&
             !(under_limit && cfg.under_limit_action == `UNDER_STOP);

    unique case (r_q.st)
      S_IDLE: begin
        if (run_ok && !fault_active) begin
          r_d = begin_start(r_d, cfg);
        end
      end
      S_PRE_BRAKE: begin
        if (timer_done) begin
          r_d.o.brake_active = 1'b0;
          r_d.o.brake_level = 10'h000;
          r_d.st = S_HOLD;
          r_d.o.freq = cfg.direct_start_freq;
          r_d.timer = ticks_of({7'h00, cfg.start_freq_hold_time}, 1'b1);
        end
      end
      S_TRACK: begin
        if (track_done) begin
          r_d.o.track_req = 1'b0;
          r_d.o.freq = track_freq;
          r_d.st = S_RUN;
        end
      end
      S_HOLD: begin
        if (timer_done) begin
          r_d.st = S_RUN;
        end
      end
      S_RUN: begin
        if (!run_ok) begin
          r_d.st = S_DECEL;
        end else if (r_q.dir_s2 != r_q.o.dir) begin
          r_d.st = S_REV_DECEL;
        end else if (under_limit && cfg.under_limit_action == `UNDER_SLEEP) begin
          r_d.st = S_DECEL;
          r_d.sleep_pend = 1'b1;
        end else if (r_q.tick) begin
          r_d.o.freq = ramp_to(r_q.o.freq, goal, cfg.accel_step, cfg.decel_step,
                               r_d.o.s_curve_active);
        end
      end
      S_DECEL: begin
        if (run_ok && !r_q.sleep_pend) begin
          r_d.st = S_RUN;
        end else if (r_q.o.freq <= cfg.stop_brake_threshold_freq &&
                     (r_q.sleep_pend || cfg.stop_brake_time == 13'h0000)) begin
          // No stop braking: finish the ramp to standstill
          if (r_q.o.freq == 16'h0000) begin
            r_d.o.pwm_enable = 1'b0;
            r_d.o.running = 1'b0;
            r_d.st = r_q.sleep_pend ? S_SLEEP : S_IDLE;
            r_d.o.sleeping = r_q.sleep_pend;
            r_d.timer = ticks_of(cfg.sleep_wake_delay, 1'b1);
          end else if (r_q.tick) begin
            r_d.o.freq = ramp_to(r_q.o.freq, 16'h0000, cfg.accel_step, cfg.decel_step,
                                 r_d.o.s_curve_active);
          end
        end else if (r_q.o.freq <= cfg.stop_brake_threshold_freq) begin
          r_d.st = S_STOP_WAIT;
          r_d.o.freq = 16'h0000;
          r_d.o.pwm_enable = 1'b0;
          r_d.timer = ticks_of({3'h0, cfg.stop_brake_wait_time}, 1'b0);
        end else if (r_q.tick) begin
          r_d.o.freq = ramp_to(r_q.o.freq, 16'h0000, cfg.accel_step, cfg.decel_step,
                               r_d.o.s_curve_active);
        end
      end
      S_STOP_WAIT: begin
        if (timer_done) begin
          r_d.st = S_STOP_BRAKE;
          r_d.o.pwm_enable = 1'b1;
          r_d.o.brake_active = 1'b1;
          r_d.o.brake_level = cfg.stop_brake_current;
          r_d.timer = ticks_of({3'h0, cfg.stop_brake_time}, 1'b0);
        end
      end
      S_STOP_BRAKE: begin
        if (timer_done) begin
          r_d.st = S_IDLE;
          r_d.o.pwm_enable = 1'b0;
          r_d.o.running = 1'b0;
          r_d.o.brake_active = 1'b0;
          r_d.o.brake_level = 10'h000;
        end
      end
      S_REV_DECEL: begin
        if (!run_ok) begin
          r_d.st = S_DECEL;
        end else if (rev_point) begin
          r_d.st = S_DEAD;
          r_d.o.freq = 16'h0000;
          r_d.timer = ticks_of(cfg.reversal_dead_time, 1'b1);
        end else if (r_q.tick) begin
          r_d.o.freq = ramp_to(r_q.o.freq, 16'h0000, cfg.accel_step, cfg.decel_step,
                               r_d.o.s_curve_active);
        end
      end
      S_DEAD: begin
        if (!run_ok) begin
          r_d.st = S_DECEL;
        end else if (timer_done) begin
          r_d.o.dir = r_q.dir_s2;
          r_d.st = S_HOLD;
          r_d.o.freq = cfg.direct_start_freq;
          r_d.timer = ticks_of({7'h00, cfg.start_freq_hold_time}, 1'b1);
        end
      end
      S_SLEEP: begin
        if (!run_ok) begin
          r_d.st = S_IDLE;
          r_d.o.sleeping = 1'b0;
        end else if (under_limit) begin
          r_d.timer = ticks_of(cfg.sleep_wake_delay, 1'b1);
        end else if (timer_done) begin
          r_d = begin_start(r_d, cfg);
        end
      end
      S_OUTAGE: begin
        if (r_q.sup_s2) begin
          if (cfg.outage_restart_enable && r_q.was_running && r_q.run_s2) begin
            r_d.st = S_RESTART;
            r_d.timer = ticks_of(cfg.outage_restart_wait, 1'b1);
          end else begin
            // Treated as a fresh power-up
            r_d.st = S_IDLE;
            r_d.start_block = r_q.run_s2 && cfg.terminal_channel &&
                              cfg.poweron_run_guard != `GUARD_HONOUR;
          end
        end
      end
      S_RESTART: begin
        if (!r_q.run_s2) begin
          r_d.st = S_IDLE;
        end else if (timer_done) begin
          r_d = begin_start(r_d, cfg);
        end
      end
    endcase

    // Supply loss and faults cut output at once, whatever the phase
    if ((!r_q.sup_s2 && r_q.init_cnt == `INIT_SETTLE) || fault_active) begin
      if (!r_q.sup_s2 && r_q.init_cnt == `INIT_SETTLE) begin
        r_d.st = S_OUTAGE;
        if (r_q.st != S_OUTAGE) begin
          r_d.was_running = r_q.o.running;
        end
      end else begin
        r_d.st = S_IDLE;
      end
      r_d.o.freq = 16'h0000;
      r_d.o.pwm_enable = 1'b0;
      r_d.o.running = 1'b0;
      r_d.o.brake_active = 1'b0;
      r_d.o.brake_level = 10'h000;
      r_d.o.track_req = 1'b0;
      r_d.o.sleeping = 1'b0;
      r_d.sleep_pend = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk) begin
    if (rst) begin
      r_q <= '0;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  assign drv = r_q.o;

endmodule
`default_nettype wire

// ---- tb/seq_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "start_stop_consts.svh"

module seq_monitor
  import start_stop_pkg::*;
(
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Supply and fault
  input wire logic supply_ok,
  input wire logic fault_active,
  input wire logic [15:0] meas_freq,
  // Settings and drive commands
  input wire cfg_t cfg,
  input wire drive_out_t drv
);
  ////////////////////////////////////////////////////////////////
  // Cycles since reset; supply is only acted on once settled
  logic [3:0] up_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      up_q <= 4'h0;
    end else if (ce && up_q != 4'hf) begin
      up_q <= up_q + 4'h1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_supply_gone;
    (up_q == 4'hf && ce && !supply_ok) [*4];
  endsequence
  sequence s_direct_launch;
    $rose(drv.running) && !$past(drv.sleeping) && cfg.start_method_select == `START_DIRECT;
  endsequence

  ////////////////////////////////////////////////////////////////
  a_reset_clear: assert property ($fell(rst) |-> drv == '0)
    else $error("drive outputs not cleared by reset");
  a_fault_off: assert property (fault_active && ce |=> !drv.pwm_enable && !drv.running)
    else $error("fault did not stop the drive");
  a_ramp_flag: assert property ((ce && drv.running) ##1 drv.running |->
    drv.s_curve_active == $past(cfg.ramp_profile_select))
    else $error("ramp profile flag wrong");
  a_brake_level: assert property (drv.brake_active |->
    drv.brake_level == cfg.stop_brake_current ||
    drv.brake_level == cfg.prestart_brake_current)
    else $error("brake level not a programmed current");
  a_brake_drive: assert property (drv.brake_active |-> drv.pwm_enable)
    else $error("brake without output stage");
  a_track_code: assert property (drv.track_req |->
    drv.track_variant == (cfg.start_method_select == `START_TRACK_TWO))
    else $error("tracking variant wrong");
  a_direct_launch: assert property (s_direct_launch |->
    drv.freq == cfg.direct_start_freq && drv.pwm_enable)
    else $error("direct start not at starting frequency");
  a_supply_cut: assert property (s_supply_gone |->
    !drv.pwm_enable && !drv.running && drv.freq == 16'h0000)
    else $error("drive still on after supply loss");
  a_halt_flag: assert property (ce |=> drv.halt_reached ==
    ((($past(cfg.halt_speed_source_select) && !$past(cfg.svpwm_mode)) ?
      $past(meas_freq) : $past(drv.freq)) <= $past(cfg.halt_speed_threshold)))
    else $error("halt flag disagrees with halt speed");
  a_ce_freeze: assert property (!ce |=> $stable(drv))
    else $error("outputs moved with enable low");
  a_sleep_quiet: assert property (drv.sleeping |->
    !drv.pwm_enable && drv.freq == 16'h0000)
    else $error("output active while asleep");
endmodule

bind drive_start_stop_sequencer seq_monitor mon (.mclk(mclk), .rst(rst), .ce(ce),
  .supply_ok(supply_ok), .fault_active(fault_active), .meas_freq(meas_freq), .cfg(cfg),
  .drv(drv));
`default_nettype wire

// ---- tb/motor_load_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module motor_load_model
  import start_stop_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Slow tracking answer
  input wire logic slow,
  // Inverter side
  input wire drive_out_t drv,
  output logic [15:0] meas_freq,
  output logic track_done,
  output logic [15:0] track_freq
);
  // Induction rotor: every start method suits it
  logic [7:0] wait_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      meas_freq <= 16'h0000;
      wait_q <= 8'h00;
      track_done <= 1'b0;
      track_freq <= 16'h0000;
    end else begin
      // Rotor lags the drive, coasts down when unpowered
      if (drv.pwm_enable) begin
        meas_freq <= 16'((17'(meas_freq) + 17'(drv.freq)) >> 1);
      end else if (meas_freq != 16'h0000) begin
        meas_freq <= meas_freq - 16'h0001;
      end
      // Search result held stable until the request drops
      if (!drv.track_req) begin
        wait_q <= 8'h00;
        track_done <= 1'b0;
      end else if (wait_q == (slow ? 8'h40 : 8'h04)) begin
        track_done <= 1'b1;
      end else begin
        wait_q <= wait_q + 8'h01;
        if (wait_q == 8'h00) track_freq <= meas_freq;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/drive_start_stop_sequencer_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
`define WT(c, n) for (int k = 0; k < (n) && !(c); k++) @(negedge mclk);

module drive_start_stop_sequencer_tb;
  import start_stop_pkg::*;
  localparam int TK = 4;
  logic mclk = 0, rst = 1, ce = 1, run_cmd = 0, dir_cmd = 0, supply_ok = 1;
  logic fault_active = 0, fault_auto_reset = 0, slow = 0, track_done;
  logic [15:0] target_freq = 16'h0100, track_freq, meas_freq;
  cfg_t cfg = '0;
  drive_out_t drv, f;
  int mismatches = 0, compares = 0, seed = 19873, n;

  always #5 mclk = ~mclk;

  drive_start_stop_sequencer #(.TICK_CYCLES(TK)) uut (.mclk, .rst, .ce, .run_cmd, .dir_cmd,
    .supply_ok, .fault_active, .fault_auto_reset, .track_done, .track_freq, .target_freq,
    .meas_freq, .cfg, .drv);
  motor_load_model pm (.mclk, .rst, .slow, .drv, .meas_freq, .track_done, .track_freq);

  ////////////////////////////////////////////////////////////////
  // Settings in 0.1 s and 0.01 s units turned into cycles
  function automatic int ten_cyc(input int t);
    return t * 10 * TK;
  endfunction
  function automatic int hund_cyc(input int t);
    return t * TK;
  endfunction
  task automatic step(input int c);
    repeat (c) @(negedge mclk);
  endtask
  task automatic stop_idle();
    run_cmd = 0;
    step(1);
    `WT(drv.running === 1'b0 && drv.pwm_enable === 1'b0, 3000)
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run is a few thousand cycles; the limit leaves ample room
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    cfg.direct_start_freq = 16'h0032;
    cfg.start_freq_hold_time = 9'h001;
    cfg.accel_step = 16'h0040;
    cfg.decel_step = 16'h0040;
    cfg.halt_speed_threshold = 16'h0032;
    cfg.halt_speed_source_select = 1'b1;
    cfg.terminal_channel = 1'b1;
    cfg.reversal_dead_time = 16'h0001;
    cfg.sleep_wake_delay = 16'h0001;
    cfg.outage_restart_wait = 16'h0001;
    cfg.prestart_brake_time = 13'h0002;
    target_freq = 16'h0100 + 16'($random(seed) & 8'hff);
    run_cmd = 1;
    step(3);
    rst = 0;
    step(30);
    `CHK(drv.running, 1'b0)
    run_cmd = 0;
    step(4);
    run_cmd = 1;
    `WT(drv.running === 1'b1, 10)
    `CHK(drv.freq, cfg.direct_start_freq)
    step(ten_cyc(1) - 10);
    `CHK(drv.freq, cfg.direct_start_freq)
    step(30);
    `CHK(drv.freq > cfg.direct_start_freq, 1'b1)
    $display("test power-up and hold done");
    `WT(drv.freq === target_freq, 400)
    cfg.stop_brake_threshold_freq = 16'h0080;
    cfg.stop_brake_wait_time = 13'h0001;
    cfg.stop_brake_current = 10'($random(seed) & 9'h1ff);
    cfg.stop_brake_time = 13'h0002;
    run_cmd = 0;
    `WT(drv.brake_active === 1'b1, 400)
    `CHK(drv.brake_level, cfg.stop_brake_current)
    n = 0;
    while (drv.brake_active === 1'b1 && n < 50) begin
      n++;
      step(1);
    end
    `CHK(n >= hund_cyc(2) && n <= hund_cyc(3), 1'b1)
    `CHK(drv.pwm_enable, 1'b0)
    cfg.stop_brake_time = 13'h0000;
    $display("test stop brake done");
    for (int m = 0; m < 4; m++) begin
      cfg.start_method_select = 2'(m);
      cfg.ramp_profile_select = m[0];
      cfg.prestart_brake_current = 10'($random(seed) & 9'h1ff);
      slow = (m == 3);
      run_cmd = 1;
      `WT(drv.pwm_enable === 1'b1 || drv.track_req === 1'b1, 20)
      if (m == 1) begin
        `CHK(drv.brake_level, cfg.prestart_brake_current)
        `WT(drv.brake_active !== 1'b1, 20)
        `CHK(drv.freq, cfg.direct_start_freq)
      end else if (m > 1) begin
        `CHK(drv.track_variant, m[0])
        `WT(drv.track_req !== 1'b1, 300)
        `CHK(drv.freq, track_freq)
      end else begin
        `CHK(drv.freq, cfg.direct_start_freq)
      end
      `WT(drv.freq === target_freq, 400)
      `CHK(drv.s_curve_active, m[0])
      stop_idle();
    end
    $display("test start methods done");
    cfg.start_method_select = 2'h0;
    cfg.ramp_profile_select = 1'b0;
    cfg.start_freq_hold_time = 9'h000;
    run_cmd = 1;
    for (int p = 0; p < 3; p++) begin
      cfg.reversal_policy_select = 2'(p);
      `WT(drv.freq === target_freq, 400)
      dir_cmd = ~dir_cmd;
      n = 0;
      for (int k = 0; k < 1000 && drv.dir !== dir_cmd; k++) begin
        if (drv.freq === 16'h0000 && drv.pwm_enable === 1'b1) n++;
        step(1);
      end
      `CHK(drv.dir, dir_cmd)
      `CHK(n >= ten_cyc(1), 1'b1)
    end
    $display("test reversal done");
    cfg.lower_limit_freq = 16'h0080;
    for (int a = 0; a < 3; a++) begin
      cfg.under_limit_action = 2'(a);
      target_freq = 16'h0040;
      step(200);
      if (a == 0) begin
        `CHK(drv.freq, cfg.lower_limit_freq)
      end else if (a == 1) begin
        `CHK(drv.running, 1'b0)
      end else begin
        `CHK(drv.sleeping, 1'b1)
        target_freq = 16'h0100;
        n = 0;
        while (drv.sleeping === 1'b1 && n < 300) begin
          n++;
          step(1);
        end
        `CHK(n >= ten_cyc(1) && n < 300, 1'b1)
      end
      target_freq = 16'h0100;
      stop_idle();
      run_cmd = 1;
      `WT(drv.freq === target_freq, 400)
    end
    $display("test under limit done");
    for (int e = 0; e < 2; e++) begin
      cfg.outage_restart_enable = e[0];
      supply_ok = 0;
      step(10);
      `CHK(drv.pwm_enable, 1'b0)
      supply_ok = 1;
      n = 0;
      while (drv.running !== 1'b1 && n < 200) begin
        n++;
        step(1);
      end
      `CHK(n >= ten_cyc(1) && n < 200, e[0])
      run_cmd = 0;
      step(5);
      run_cmd = 1;
      `WT(drv.freq === target_freq, 400)
    end
    $display("test outage done");
    cfg.svpwm_mode = 1'b1;
    fault_active = 1;
    step(1);
    fault_active = 0;
    step(20);
    `CHK(drv.running, 1'b0)
    `CHK(drv.halt_reached, 1'b1)
    fault_auto_reset = 1;
    step(1);
    fault_auto_reset = 0;
    `WT(drv.running === 1'b1, 10)
    `CHK(drv.running, 1'b1)
    ce = 0;
    f = drv;
    step(6);
    `CHK(drv, f)
    ce = 1;
    for (int g = 0; g < 2; g++) begin
      cfg.poweron_run_guard = g[0];
      rst = 1;
      step(2);
      rst = 0;
      step(30);
      `CHK(drv.running, g[0])
    end
    $display("test fault and power-up guard done");
    end_sim();
  end
endmodule
`default_nettype wire
